// ==== hdl/bert_pkg.sv ====
// Register map, constants and helper functions of the pattern checker
package bert_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00; // Mode and options
  localparam logic [7:0] PLEN_OFS = 8'h04; // Program pattern length
  localparam logic [7:0] STAT_OFS = 8'h08; // Sync and frame lock
  localparam logic [7:0] ECNT_OFS = 8'h0c; // Counted bit errors
  localparam logic [7:0] OHAD_OFS = 8'h10; // Overhead table index
  localparam logic [7:0] OHDT_OFS = 8'h14; // Overhead table byte
  localparam logic [2:0] PAT_PAGE = 3'h1;  // 0x20..0x3c pattern words
  // ------------------------------------------------------------------
  // Control fields and reset values
  // ------------------------------------------------------------------
  localparam int ORD_LSB = 2;  // Order select, 3 bits
  localparam int AUTO_BIT = 5; // Automatic alignment
  localparam int POL_BIT = 6;  // 1: positive logic
  localparam int INS_BIT = 8;  // Write 1: insert one fault
  localparam int CLR_BIT = 9;  // Write 1: clear error count
  localparam logic [6:0] CTRL_RST = 7'h60;
  localparam logic [26:0] PLEN_RST = 27'h0000100;
  localparam logic [30:0] LFSR_SEED = 31'h7fffffff;
  localparam logic [6:0] SCR_SEED = 7'h7f;
  typedef enum logic [1:0] {
    M_PRBS = 2'b00, M_SHORT = 2'b01, M_LONG = 2'b10, M_FRAME = 2'b11
  } mode_t;
  // ------------------------------------------------------------------
  // Windows and thresholds, in bits and errors
  // ------------------------------------------------------------------
  localparam int PRBS_LOSS_WIN = 8192;
  localparam int PRBS_LOSS_THR = 1024;
  localparam int PRBS_ACQ_WIN = 128;
  localparam int PRBS_ACQ_THR = 2;
  localparam int PROG_WIN = 16384;
  localparam int SHORT_LOSS_THR = 128;
  localparam int SHORT_ACQ_THR = 32;
  localparam int LONG_LOSS_THR = 8;
  localparam int LONG_ACQ_THR = 2;
  localparam int READIN_DEPTH = 4096; // Captured reference bits
  localparam logic [6:0] TRIG_LAST = 7'h7f; // 128-bit block end
  // ------------------------------------------------------------------
  // Frame geometry: position is {row, byte column, bit}
  // ------------------------------------------------------------------
  typedef logic [21:0] fpos_t;
  localparam logic [14:0] COL_LAST = 15'h437f; // 17280 bytes a row
  localparam logic [14:0] OH_COLS = 15'h0240;  // 576 overhead bytes
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam int OH_BYTES = 5184;
  localparam logic [31:0] ALIGN_WORD = 32'hf6f62828;
  localparam fpos_t ALIGN_POS = {4'h0, 15'h00c1, 3'h7};

  // Feedback bit of the selected maximal-length register
  function automatic logic prbs_fb(logic [30:0] s, logic [2:0] o);
    unique case (o)
      3'h0: return s[6] ^ s[5];
      3'h1: return s[8] ^ s[4];
      3'h2: return s[9] ^ s[6];
      3'h3: return s[10] ^ s[8];
      3'h4: return s[14] ^ s[13];
      3'h5: return s[22] ^ s[17];
      default: return s[30] ^ s[27];
    endcase
  endfunction

  // Next bit position inside the frame
  function automatic fpos_t fpos_next(fpos_t p);
    if (p[2:0] != 3'h7) return {p[21:3], p[2:0] + 3'h1};
    if (p[17:3] != COL_LAST) return {p[21:18], p[17:3] + 15'h1, 3'h0};
    if (p[21:18] != ROW_LAST) return {p[21:18] + 4'h1, 18'h0};
    return '0;
  endfunction

  // Scrambler state at a bit; reloads after the first overhead row
  function automatic logic [6:0] scr_cur(fpos_t p, logic [6:0] s);
    return (p == {4'h0, OH_COLS, 3'h0}) ? SCR_SEED : s;
  endfunction

  // Read-in window: eight times the length bracket, 0 below 2049
  function automatic logic [29:0] long_win(logic [26:0] n);
    if (n <= 27'h0000800) return '0;
    if (n <= 27'h0002000) return 30'h00010000;
    if (n <= 27'h0008000) return 30'h00040000;
    if (n <= 27'h0020000) return 30'h00100000;
    if (n <= 27'h0080000) return 30'h00400000;
    for (int k = 20; k < 26; k++) begin
      if (n <= (27'h1 << k)) return 30'(30'h8 << k);
    end
    return 30'h20000000;
  endfunction
endpackage

// ==== hdl/bert_pattern_sync_checker.sv ====
// Pattern generator and sync checker of a bit-error-rate tester
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// [RQ1] Fault trigger high 128 bits per error
// [RQ2] Trigger blocks use a free internal boundary
// [RQ3] Order N sequence repeats every 2^N-1 bits
// [RQ4] Positive logic sends one as low
// [RQ5] Sequence mark ratio fixed at one half
// [RQ6] Auto alignment compares and reacquires by itself
// [RQ7] No error counting while auto and unsynced
// [RQ8] Auto off after lock: hold, keep counting
// [RQ9] Auto off: no new alignment attempts
// [RQ10] Loss when window errors exceed threshold
// [RQ11] Sync when window errors within threshold
// [RQ12] Random: loss >1024/8192, sync <=2/128
// [RQ13] Short program: 16384 windows, 128 / 32
// [RQ14] Long program: >8 loss, <=2 sync
// [RQ15] Selector at B unless auto alignment
// [RQ16] Short program slips one bit on mismatch
// [RQ17] Long program captures received reference
// [RQ18] Frame payload random, orders 9 to 31
// [RQ19] Scramble all but first overhead row
// [RQ20] Overhead bytes from rewritable table
// [RQ21] Parity bytes sent from table unchanged
// [RQ22] Frame lock on word in two frames
// [RQ23] Maximal-length registers, customary taps
module bert_pattern_sync_checker #(
  parameter int LOSS_WIN_PRBS = bert_pkg::PRBS_LOSS_WIN,
  parameter int WIN_PROG = bert_pkg::PROG_WIN
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_data,
  output logic tx_data,
  output logic inserted_fault_trigger,
  output logic detected_fault_trigger
);
  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [6:0] ctrl; // Mode, order, auto, polarity
  logic [26:0] plen; // Program pattern length in bits
  logic [255:0] prog; // Stored short program pattern
  logic [7:0] oh_tab [0:bert_pkg::OH_BYTES-1]; // Overhead bytes
  logic [12:0] oh_addr; // Table index, steps on each data access
  logic ref_mem [0:bert_pkg::READIN_DEPTH-1]; // Captured reference
  logic [31:0] errcnt; // Counted errors
  logic ins_req; // Pending fault insertion

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic hit_ctrl = paddr == bert_pkg::CTRL_OFS;
  wire logic hit_plen = paddr == bert_pkg::PLEN_OFS;
  wire logic hit_stat = paddr == bert_pkg::STAT_OFS;
  wire logic hit_ecnt = paddr == bert_pkg::ECNT_OFS;
  wire logic hit_ohad = paddr == bert_pkg::OHAD_OFS;
  wire logic hit_ohdt = paddr == bert_pkg::OHDT_OFS;
  wire logic hit_pat = paddr[7:5] == bert_pkg::PAT_PAGE;
  wire logic mapped = hit_ctrl | hit_plen | hit_stat | hit_ecnt |
                      hit_ohad | hit_ohdt | hit_pat;
  wire logic [7:0] pat_sel = {paddr[4:2], 5'h00};

  assign pready = acc; // Zero wait states
  assign pslverr = acc & ~mapped;

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  wire bert_pkg::mode_t mode = bert_pkg::mode_t'(ctrl[1:0]);
  wire logic [2:0] ord = ctrl[bert_pkg::ORD_LSB +: 3];
  wire logic autos = ctrl[bert_pkg::AUTO_BIT];
  wire logic pol = ctrl[bert_pkg::POL_BIT];
  wire logic is_frame = mode == bert_pkg::M_FRAME;
  wire logic is_short = mode == bert_pkg::M_SHORT;
  wire logic is_long = mode == bert_pkg::M_LONG;
  // Frame payload has no order 7; that code falls back to order 9
  wire logic [2:0] ford = (ord == 3'h0) ? 3'h1 : ord; // RQ18
  wire logic [2:0] cord = is_frame ? ford : ord;
  // Pattern pointer wraps at the length, capped by the capture depth
  wire logic [11:0] wrap = (plen > 27'(bert_pkg::READIN_DEPTH)) ?
                           12'hfff : 12'(plen - 27'h1);

  // ------------------------------------------------------------------
  // Transmit side
  // ------------------------------------------------------------------
  logic [30:0] tx_lfsr; // Payload and plain random source
  bert_pkg::fpos_t tx_fp; // Frame position of the next bit
  logic [6:0] tx_scr; // Frame scrambler
  logic [11:0] tx_ptr; // Short program pointer
  wire logic tx_pl = tx_fp[17:3] >= bert_pkg::OH_COLS;
  wire logic tx_row0 = tx_fp[21:18] == 4'h0;
  // Overhead byte, parity bytes included, is sent as stored
  wire logic [12:0] tx_oh = 13'(tx_fp[21:18]) * 13'h0240 +
                            13'(tx_fp[17:3]); // RQ20 RQ21
  wire logic tx_ohb = oh_tab[tx_oh][~tx_fp[2:0]];
  wire logic tx_fb = bert_pkg::prbs_fb(tx_lfsr, cord); // RQ23
  wire logic [6:0] tx_sc = bert_pkg::scr_cur(tx_fp, tx_scr);
  wire logic tx_scen = ~(tx_row0 & ~tx_pl); // RQ19
  wire logic tx_frm = (tx_pl ? tx_fb : tx_ohb) ^ (tx_scen & tx_sc[6]);
  wire logic tx_step = ~is_frame | tx_pl;
  logic tx_bit;
  always_comb begin
    unique case (mode)
      bert_pkg::M_SHORT: tx_bit = prog[tx_ptr[7:0]];
      bert_pkg::M_FRAME: tx_bit = tx_frm;
      default: tx_bit = tx_fb; // RQ5
    endcase
  end

  // Generators step once per bit; the random source holds over frame overhead bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_lfsr <= bert_pkg::LFSR_SEED;
      tx_fp <= '0;
      tx_scr <= bert_pkg::SCR_SEED;
      tx_ptr <= '0;
    end else begin
      if (tx_step) begin
        tx_lfsr <= {tx_lfsr[29:0], tx_fb}; // RQ3
      end
      tx_fp <= bert_pkg::fpos_next(tx_fp);
      tx_scr <= {tx_sc[5:0], tx_sc[6] ^ tx_sc[5]};
      tx_ptr <= (tx_ptr == wrap) ? '0 : tx_ptr + 12'h1;
    end
  end

  // Line level; a pending insertion flips exactly one bit
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_data <= 1'b0;
    end else begin
      tx_data <= tx_bit ^ ins_req ^ pol; // RQ4
    end
  end

  // ------------------------------------------------------------------
  // Receive side: pin synchroniser and frame alignment
  // ------------------------------------------------------------------
  logic rx_m, rx_s; // Two flops ahead of any logic
  logic [30:0] rx_sh; // Recent bits for the alignment word
  bert_pkg::fpos_t rx_fp; // Frame position of the current bit
  logic f_seen, f_lock; // Word seen once, word seen twice
  logic [6:0] rx_scr;
  wire logic rx_b = rx_s ^ pol; // Logical value
  wire logic [31:0] rx_word = {rx_sh, rx_b};
  wire logic at_align = rx_fp == bert_pkg::ALIGN_POS;
  wire logic word_hit = rx_word == bert_pkg::ALIGN_WORD;
  wire logic rx_pl = rx_fp[17:3] >= bert_pkg::OH_COLS;
  wire logic rx_row0 = rx_fp[21:18] == 4'h0;
  wire logic [6:0] rx_sc = bert_pkg::scr_cur(rx_fp, rx_scr);
  wire logic rx_d = rx_b ^ (~(rx_row0 & ~rx_pl) & rx_sc[6]); // RQ19

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_m <= 1'b0;
      rx_s <= 1'b0;
      rx_sh <= '0;
    end else begin
      rx_m <= rx_data;
      rx_s <= rx_m;
      rx_sh <= rx_word[30:0];
    end
  end

  // Word at the expected spot twice in a row locks; a miss drops it
  always_ff @(posedge clk) begin
    if (!rstn || !is_frame) begin
      rx_fp <= '0;
      f_seen <= 1'b0;
      f_lock <= 1'b0;
      rx_scr <= bert_pkg::SCR_SEED;
    end else begin
      rx_scr <= {rx_sc[5:0], rx_sc[6] ^ rx_sc[5]};
      if (word_hit) begin
        f_lock <= f_seen & at_align; // RQ22
        f_seen <= 1'b1;
        rx_fp <= bert_pkg::fpos_next(bert_pkg::ALIGN_POS);
      end else begin
        if (at_align) begin
          f_seen <= 1'b0;
          f_lock <= 1'b0;
        end
        rx_fp <= bert_pkg::fpos_next(rx_fp);
      end
    end
  end

  // ------------------------------------------------------------------
  // Comparison against the reference
  // ------------------------------------------------------------------
  logic [30:0] ref_lfsr; // Reference generator
  logic [11:0] rp; // Program or capture pointer
  logic cap; // Capturing a reference from the line
  logic sync; // Pattern alignment established
  wire logic sel_a = autos & ~sync; // RQ15
  wire logic chk_in = is_frame ? rx_d : rx_b;
  wire logic valid = is_frame ? (f_lock & rx_pl) : ~(is_long & cap);
  wire logic ref_fb = bert_pkg::prbs_fb(ref_lfsr, cord); // RQ23
  logic exp_b;
  always_comb begin
    unique case (mode)
      bert_pkg::M_SHORT: exp_b = prog[rp[7:0]];
      bert_pkg::M_LONG: exp_b = ref_mem[rp];
      default: exp_b = ref_fb;
    endcase
  end
  wire logic err = valid & (chk_in ^ exp_b);
  wire logic slip = is_short & sel_a & err; // RQ16
  // Sync-lost errors are not counted under auto alignment
  wire logic cnt_ev = err & ~sel_a; // RQ7 RQ8

  // Reference paths: self-seed at A, free-run at B; slip or capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_lfsr <= bert_pkg::LFSR_SEED;
      rp <= '0;
    end else begin
      if (valid | is_long) begin
        ref_lfsr <= {ref_lfsr[29:0], sel_a ? chk_in : ref_fb}; // RQ6
      end
      if (!slip) begin
        rp <= (rp == wrap) ? '0 : rp + 12'h1;
      end
    end
  end

  // Read-in store: one pattern length of received bits
  always_ff @(posedge clk) begin
    if (is_long && cap) begin
      ref_mem[rp] <= rx_b; // RQ17
    end
  end

  // ------------------------------------------------------------------
  // Sync windows
  // ------------------------------------------------------------------
  logic [29:0] win_cnt, win_err;
  logic [29:0] win_len, loss_thr, acq_thr;
  wire logic [29:0] lw = bert_pkg::long_win(plen);
  always_comb begin
    unique case (mode)
      bert_pkg::M_SHORT: begin
        win_len = 30'(WIN_PROG); // RQ13
        loss_thr = 30'(bert_pkg::SHORT_LOSS_THR);
        acq_thr = 30'(bert_pkg::SHORT_ACQ_THR);
      end
      bert_pkg::M_LONG: begin
        win_len = (lw == '0) ? 30'(WIN_PROG) : lw; // RQ14
        loss_thr = 30'(bert_pkg::LONG_LOSS_THR);
        acq_thr = 30'(bert_pkg::LONG_ACQ_THR);
      end
      default: begin
        win_len = sync ? 30'(LOSS_WIN_PRBS) :
                  30'(bert_pkg::PRBS_ACQ_WIN); // RQ12
        loss_thr = 30'(bert_pkg::PRBS_LOSS_THR);
        acq_thr = 30'(bert_pkg::PRBS_ACQ_THR);
      end
    endcase
  end
  wire logic win_end = valid & (win_cnt == win_len - 30'h1);
  wire logic [29:0] win_tot = win_err + 30'(err);
  wire logic go_sync = ~sync & (win_tot <= acq_thr); // RQ11
  wire logic go_loss = sync & (win_tot > loss_thr); // RQ10

  // Decisions only under auto alignment; otherwise state holds
  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_cnt <= '0;
      win_err <= '0;
      sync <= 1'b0;
      cap <= 1'b1;
    end else if (win_end) begin
      win_cnt <= '0;
      win_err <= '0;
      if (autos) begin // RQ8 RQ9
        sync <= go_sync | (sync & ~go_loss);
        cap <= ~(go_sync | (sync & ~go_loss)); // RQ6 RQ17
      end
    end else begin
      if (valid) begin
        win_cnt <= win_cnt + 30'h1;
      end
      win_err <= win_tot;
      if (is_long && cap && rp == wrap) begin
        cap <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Fault triggers on a free 128-bit block
  // ------------------------------------------------------------------
  logic [6:0] blk; // Block boundary unrelated to the data
  logic pend_i, pend_d; // Events seen in the current block
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blk <= '0;
      pend_i <= 1'b0;
      pend_d <= 1'b0;
      inserted_fault_trigger <= 1'b0;
      detected_fault_trigger <= 1'b0;
    end else begin
      blk <= blk + 7'h1; // RQ2
      if (blk == bert_pkg::TRIG_LAST) begin
        // Errors in one block light the whole next block
        inserted_fault_trigger <= pend_i | ins_req; // RQ1
        detected_fault_trigger <= pend_d | cnt_ev; // RQ1
        pend_i <= 1'b0;
        pend_d <= 1'b0;
      end else begin
        pend_i <= pend_i | ins_req;
        pend_d <= pend_d | cnt_ev;
      end
    end
  end

  // ------------------------------------------------------------------
  // Register writes and error count
  // ------------------------------------------------------------------
  wire logic clr = wr & hit_ctrl & pwdata[bert_pkg::CLR_BIT];
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl <= bert_pkg::CTRL_RST;
      plen <= bert_pkg::PLEN_RST;
      prog <= '0;
      oh_addr <= '0;
      ins_req <= 1'b0;
      errcnt <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl <= pwdata[6:0];
      end
      if (wr && hit_plen) begin
        plen <= pwdata[26:0];
      end
      if (wr && hit_pat) begin
        prog[pat_sel +: 32] <= pwdata;
      end
      if (wr && hit_ohad) begin
        oh_addr <= pwdata[12:0];
      end else if (acc && hit_ohdt) begin
        oh_addr <= oh_addr + 13'h1;
      end
      // A new request wins over the one being consumed
      ins_req <= wr & hit_ctrl & pwdata[bert_pkg::INS_BIT];
      // A counted error in the clearing cycle survives as one
      errcnt <= clr ? 32'(cnt_ev) : errcnt + 32'(cnt_ev);
    end
  end

  // Overhead table written one byte at a time
  always_ff @(posedge clk) begin
    if (wr && hit_ohdt) begin
      oh_tab[oh_addr] <= pwdata[7:0]; // RQ20
    end
  end

  // ------------------------------------------------------------------
  // Read data, latched in the setup cycle
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) rd_mux = {25'h0, ctrl};
    if (hit_plen) rd_mux = {5'h0, plen};
    if (hit_stat) rd_mux = {29'h0, cap, f_lock, sync};
    if (hit_ecnt) rd_mux = errcnt;
    if (hit_ohad) rd_mux = {19'h0, oh_addr};
    if (hit_ohdt) rd_mux = {24'h0, oh_tab[oh_addr]};
    if (hit_pat) rd_mux = prog[pat_sel +: 32];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end
endmodule // bert_pattern_sync_checker

// ==== tb/bert_line_partner.sv ====
// Far-side model: a device under test that echoes the line back
`timescale 1ns/1ps
module bert_line_partner (
  input wire logic clk,
  input wire logic tx_data,
  input wire logic flip,
  output logic rx_data = 1'b0
);
  // --------------------------------------------------------------
  // Echo path
  // --------------------------------------------------------------
  // One bit of line delay; flip models a receiver that inverts all
  always_ff @(posedge clk) begin
    rx_data <= tx_data ^ flip;
  end
endmodule // bert_line_partner

// ==== tb/bert_pattern_sync_checker_monitor.sv ====
// Port checker of the pattern checker, bound to its top module
`timescale 1ns/1ps
module bert_pattern_sync_checker_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_data,
  input wire logic tx_data,
  input wire logic inserted_fault_trigger,
  input wire logic detected_fault_trigger
);
  // --------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------
  logic [15:0] ins_run; // High cycles of the inserted trigger
  logic [15:0] det_run; // High cycles of the detected trigger
  // Gaps in the map answer with an error
  wire logic unmapped = (paddr == 8'h18) || (paddr == 8'h1c) ||
    (paddr > 8'h3c);
  // Run lengths restart whenever a trigger is low
  always_ff @(posedge clk) begin
    ins_run <= (rstn && inserted_fault_trigger) ? ins_run + 16'h1 : 16'h0;
    det_run <= (rstn && detected_fault_trigger) ? det_run + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // --------------------------------------------------------------
  // Sequences and assertions
  // --------------------------------------------------------------
  sequence apb_acc;
    psel && penable;
  endsequence
  sequence ins_wr;
    apb_acc ##0 (pwrite && paddr == bert_pkg::CTRL_OFS &&
      pwdata[bert_pkg::INS_BIT]);
  endsequence
  a_ready_access: assert property (apb_acc |-> pready)
    else $error("pready low in access");
  a_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("pready high outside access");
  a_err_unmapped: assert property (apb_acc ##0 unmapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (apb_acc ##0 !unmapped |-> !pslverr)
    else $error("error on mapped access");
  a_unmapped_zero: assert property (apb_acc ##0 (unmapped && !pwrite)
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  // Data loaded at the setup edge must survive the access edge
  a_read_stable: assert property (apb_acc |=> $stable(prdata))
    else $error("read data moved in access");
  a_insert_trig: assert property (ins_wr |-> ##[2:260]
    inserted_fault_trigger) else $error("no trigger after insertion");
  a_ins_width: assert property ($fell(inserted_fault_trigger) |->
    ins_run[6:0] == 7'h0 && ins_run != 16'h0)
    else $error("inserted trigger width not whole blocks");
  a_det_width: assert property ($fell(detected_fault_trigger) |->
    det_run[6:0] == 7'h0 && det_run != 16'h0)
    else $error("detected trigger width not whole blocks");
endmodule // bert_pattern_sync_checker_monitor

bind bert_pattern_sync_checker bert_pattern_sync_checker_monitor u_mon (
  .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_data(rx_data), .tx_data(tx_data),
  .inserted_fault_trigger(inserted_fault_trigger),
  .detected_fault_trigger(detected_fault_trigger));

// ==== tb/bert_pattern_sync_checker_test.sv ====
// Self-checking bench of the pattern checker over a line loopback
`timescale 1ns/1ps
module bert_pattern_sync_checker_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_data, tx_data, ins_trig, det_trig;
  logic flip = 1'b0; // Far side inverts the echoed line
  logic err; // Error flag of the last transfer
  logic [31:0] rd, rd2;
  int bad_count = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  // Short windows keep the run brief; 2048 bits still rule out a slip
  // search locking on a wrong phase with 32 errors or fewer
  bert_pattern_sync_checker #(.LOSS_WIN_PRBS(2048), .WIN_PROG(2048)) uut (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data(rx_data), .tx_data(tx_data),
    .inserted_fault_trigger(ins_trig), .detected_fault_trigger(det_trig));
  bert_line_partner peer (.clk(clk), .tx_data(tx_data), .flip(flip),
    .rx_data(rx_data));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task test_done;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      $display("[FAIL] %0t no ready", $time);
      test_done();
    end
  endtask
  // Poll the sync bit under a bound
  task wait_sync(input logic v);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, bert_pkg::STAT_OFS, 32'h0);
      if (rd[0] === v) return;
    end
    bad_count++;
    $display("[FAIL] %0t sync wait timed out", $time);
    test_done();
  endtask
  // Capture two periods of order 7; lv is the level of a logic one
  task scan(input logic lv);
    logic [126:0] s;
    int m, r, e, w;
    m = 0; r = 0; e = 0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 254; i++) begin
      // Sample away from the edge that launches the line bit
      @(negedge clk);
      if (i < 127) s[i] = tx_data;
      else if (s[i - 127] !== tx_data) e++;
    end
    for (int i = 0; i < 127; i++) begin
      w = 1;
      for (int k = 0; k < 7; k++) if (s[(i + k) % 127] !== lv) w = 0;
      r += w;
      m += (s[i] === lv);
    end
    chk(32'(e), 32'h0);
    chk(32'(r), 32'h1);
    chk(32'(m), 32'h40);
  endtask
  // Force a loss, switch mode, then reacquire with a clean count
  task resync(input logic [31:0] c);
    flip <= 1'b1;
    wait_sync(1'b0);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    rd2 = rd;
    repeat (300) @(posedge clk);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    chk(rd, rd2);
    apb(1'b1, bert_pkg::CTRL_OFS, c);
    flip <= 1'b0;
    wait_sync(1'b1);
    apb(1'b1, bert_pkg::CTRL_OFS, c | 32'h200);
    repeat (300) @(posedge clk);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, bert_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h60);
    apb(1'b0, bert_pkg::PLEN_OFS, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, bert_pkg::OHAD_OFS, 32'h5);
    apb(1'b1, bert_pkg::OHDT_OFS, 32'ha5);
    apb(1'b0, bert_pkg::OHAD_OFS, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, bert_pkg::OHAD_OFS, 32'h5);
    apb(1'b0, bert_pkg::OHDT_OFS, 32'h0);
    chk(rd, 32'ha5);
    scan(1'b0);
    apb(1'b1, bert_pkg::CTRL_OFS, 32'h20);
    scan(1'b1);
    apb(1'b1, bert_pkg::CTRL_OFS, 32'h60);
    wait_sync(1'b1);
    for (int o = 0; o < 7; o++) resync(32'h60 | (o << 2));
    // Auto off after lock: errors keep counting, lock holds
    apb(1'b1, bert_pkg::CTRL_OFS, 32'h58);
    flip <= 1'b1;
    repeat (4500) @(posedge clk);
    apb(1'b0, bert_pkg::STAT_OFS, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    rd2 = rd;
    repeat (100) @(posedge clk);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    chk({31'h0, rd > rd2}, 32'h1);
    flip <= 1'b0;
    // Let the flipped loss window close while auto is still off, and
    // keep the last flipped bits away from the clearing cycle
    repeat (2100) @(posedge clk);
    apb(1'b1, bert_pkg::CTRL_OFS, 32'h278);
    apb(1'b1, bert_pkg::CTRL_OFS, 32'h178);
    rd2 = 32'h0;
    for (int i = 0; i < 400 && rd2 == 32'h0; i++) begin
      @(negedge clk);
      if (det_trig === 1'b1) rd2 = 32'h1;
    end
    chk(rd2, 32'h1);
    apb(1'b0, bert_pkg::ECNT_OFS, 32'h0);
    chk(rd, 32'h1);
    // Short program pattern found by slipping
    apb(1'b1, 8'h20, 32'h0f35a9c3);
    apb(1'b1, bert_pkg::PLEN_OFS, 32'h20);
    resync(32'h61);
    test_done();
  end
endmodule // bert_pattern_sync_checker_test
